// ===== sfc_defs.svh
/*
  Constants of the serial flash command front end: opcodes, dummy byte
  counts, address field positions, counter limits and reset values.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// main array reads
`define SFC_OP_RD_LEGACY   8'hE8
`define SFC_OP_RD_FAST     8'h0B
`define SFC_OP_RD_SLOW     8'h03
`define SFC_OP_RD_LOWPWR   8'h01
// other opcodes, values arbitrary
`define SFC_OP_RD_BUF      8'h10
`define SFC_OP_BUF_WRITE   8'h11
`define SFC_OP_PROG_BUF    8'h12
`define SFC_OP_PROG_DIRECT 8'h13
`define SFC_OP_ER_PAGE     8'h14
`define SFC_OP_ER_BLOCK    8'h15
`define SFC_OP_ER_SECTOR   8'h16
`define SFC_OP_ER_CHIP     8'h17
`define SFC_OP_PROT_EN     8'h18
`define SFC_OP_LOCKDOWN    8'h19
`define SFC_OP_SPR_ERASE   8'h1A
`define SFC_OP_SPR_PROG    8'h1B

// dummy bytes after the address
`define SFC_DUMMY_LEGACY   3'h4
`define SFC_DUMMY_FAST     3'h1
`define SFC_DUMMY_BUF      3'h1
`define SFC_DUMMY_NONE     3'h0

// framing counters
`define SFC_BIT_LAST       3'h7
`define SFC_ADDR_LAST      3'h2
`define SFC_DUMMY_FINAL    3'h1

// address layout
`define SFC_PAGE_W         10
`define SFC_BYTE_W         9
`define SFC_STD_PAGE_LSB   9
`define SFC_BIN_PAGE_LSB   8
`define SFC_SECT_LSB       7

// reset values
`define SFC_CS_IDLE        1'b1
`define SFC_SCK_IDLE       1'b0

`endif

// ===== sfc_pkg.sv
/*
  Types of the serial flash command front end: command kinds and the
  one-hot frame states. Assumes nothing of its surroundings.
*/
package sfc_pkg;

  typedef enum logic [3:0] {
    KIND_NONE, KIND_RD_ARRAY, KIND_RD_BUF, KIND_BUF_WRITE, KIND_PROG_BUF,
    KIND_PROG_DIRECT, KIND_ER_PAGE, KIND_ER_BLOCK, KIND_ER_SECTOR, KIND_ER_CHIP,
    KIND_PROT_EN, KIND_LOCKDOWN, KIND_SPR_ERASE, KIND_SPR_PROG
  } sfc_kind_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_OPC    = 7'h02,
    ST_ADDR   = 7'h04,
    ST_DUMMY  = 7'h08,
    ST_RDATA  = 7'h10,
    ST_WDATA  = 7'h20,
    ST_IGNORE = 7'h40
  } sfc_state_t;

endpackage : sfc_pkg

// ===== sfc_byte_if.sv
/*
  Byte-level link between the serial shifter and the frame controller.
  Assumes both ends run on the same clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfc_byte_if;
  logic       rise;
  logic       fall;
  logic       csFall;
  logic       byteDone;
  logic [7:0] rxByte;
  modport src (output rise, fall, csFall, byteDone, rxByte);
  modport dst (input rise, fall, csFall, byteDone, rxByte);
endinterface : sfc_byte_if
`default_nettype wire

// ===== sfc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes D is a power of two and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // system
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wrPtr;
  logic [AW:0]  rdPtr;
  logic [AW:0]  next_wrPtr;
  logic [AW:0]  next_rdPtr;
  logic         full;
  logic         empty;
  logic         doPush;
  logic         doPop;

  // extra pointer bit tells full from empty
  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];
  assign doPush   = inValid && !full;
  assign doPop    = outReady && !empty;

  always_comb
  begin
    next_wrPtr = wrPtr + {{AW{1'b0}}, doPush};
    next_rdPtr = rdPtr + {{AW{1'b0}}, doPop};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // storage carries no reset
  always_ff @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule : sfc_fifo
`default_nettype wire

// ===== sfc_shift.sv
/*
  Serial input shifter: finds link clock edges and assembles bytes.
  Assumes csN, sck and si are synchronous to clk and sck is much slower.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_shift (
  // system
  input  wire logic clk,
  input  wire logic rst,
  // serial pins
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic resetN,
  // byte link
  sfc_byte_if.src   lnk
);
  logic       sckQ;
  logic       csQ;
  logic       done;
  logic [2:0] cnt;
  logic [7:0] sh;
  logic       next_sckQ;
  logic       next_csQ;
  logic       next_done;
  logic [2:0] next_cnt;
  logic [7:0] next_sh;

  assign lnk.rise     = !csN && sck && !sckQ;
  assign lnk.fall     = !csN && !sck && sckQ;
  assign lnk.csFall   = !csN && csQ;
  assign lnk.byteDone = done;
  assign lnk.rxByte   = sh;

  always_comb
  begin
    next_sckQ = sck;
    next_csQ  = csN;
    next_sh   = sh;
    next_cnt  = cnt;
    next_done = 1'b0;
    if (csN || !resetN)
      next_cnt = '0;
    else if (lnk.rise)
    begin
      next_sh   = {sh[6:0], si};
      next_cnt  = cnt + 3'h1;
      next_done = (cnt == `SFC_BIT_LAST);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sckQ <= `SFC_SCK_IDLE;
      csQ  <= `SFC_CS_IDLE;
      sh   <= '0;
      cnt  <= '0;
      done <= 1'b0;
    end
    else
    begin
      sckQ <= next_sckQ;
      csQ  <= next_csQ;
      sh   <= next_sh;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  a_deselect_ignored: assert property (@(posedge clk) disable iff (rst) csN |=> (cnt == '0) && !done)
    else $error("serial input taken while deselected");
endmodule : sfc_shift
`default_nettype wire

// ===== sfc_frontend.sv
/*
  Command front end of a serial flash: frames opcode, address and data
  from the serial link, gates program and erase by write protect.
  Assumes link pins synchronous to clk; array, buffer and protection
  store live in a back end behind the command and data ports.
*/
// Summary of operation
// - protected sectors refuse program and erase while write protect low, any software state.
// - protection register changes refused while write protect is low.
// - program or erase opcode under write protect is dropped; idle at deselect.
// - protection enable and lockdown still accepted under write protect.
// - write protect pin left open reads high, meaning unprotected.
// - reset pin low aborts the operation and returns the controller to idle.
// - device stays reset while reset pin low, resumes when it rises.
// - internal power-on reset; reset pin needs no sequence at power-up.
// - a frame opens with chip select falling, then opcode, then address.
// - bits shift in on si on rising clock edges only while selected.
// - every opcode, address and data byte travels msb first.
// - three address bytes, leading don't-care bits, then real address bits.
// - 264-byte pages take a nine-bit buffer byte address.
// - 264-byte pages split main address into ten-bit page, nine-bit offset.
// - 256-byte pages take an eight-bit buffer byte address.
// - 256-byte pages use bits 17..8 as page and 7..0 as offset.
// - main array and buffer reads by opcode; clock modes 0 and 3.
// - erase of chip, sector, block or page.
// - program of whole page or a variable number of bytes.
// - input sampled on rising clock edge, output changes on falling edge.
// - deselected, output is high impedance and input is ignored.
// - chip select rising ends the operation; standby waits for busy to clear.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_frontend
  import sfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int NSECT      = 8
) (
  // system
  input  wire logic             clk,
  input  wire logic             rst,
  // serial link
  input  wire logic             csN,
  input  wire logic             sck,
  input  wire logic             si,
  output logic                  so,
  output logic                  soOe,
  // device control pins
  input  wire logic             wpN,
  input  wire logic             resetN,
  // configuration
  input  wire logic             pageBin,
  input  wire logic             swProtOn,
  input  wire logic [NSECT-1:0] sectorProt,
  // command to back end
  output logic                  cmdStart,
  output logic                  cmdEnd,
  output var sfc_kind_t         cmdKind,
  output logic [9:0]            cmdPage,
  output logic [8:0]            cmdByte,
  // read data
  input  wire logic [7:0]       rdByte,
  output logic                  rdNext,
  // write data
  output logic [7:0]            wrData,
  output logic                  wrValid,
  input  wire logic             wrReady,
  output logic                  wrOverrun,
  // status
  input  wire logic             busy,
  output logic                  standby
);
  sfc_byte_if lnk ();

  sfc_state_t state, next_state;
  sfc_kind_t  kind, next_kind, opKind, next_cmdKind;
  logic [7:0]  op, next_op;
  logic [23:0] addr, next_addr;
  logic [2:0]  cnt, next_cnt;
  logic [7:0]  txSh, next_txSh;
  logic [2:0]  txCnt, next_txCnt;
  logic [7:0]  pushData, next_pushData;
  logic [9:0]  next_cmdPage;
  logic [8:0]  next_cmdByte;
  logic        push, next_push, fifoReady;
  logic        next_so, next_soOe, next_cmdStart, next_cmdEnd;
  logic        next_rdNext, next_wrOverrun, next_standby;
  logic [23:0] fullAddr;
  logic [18:0] split;
  logic [2:0]  sector;
  logic        protHit;

  sfc_shift u_shift (
    .clk    (clk),
    .rst    (rst),
    .csN    (csN),
    .sck    (sck),
    .si     (si),
    .resetN (resetN),
    .lnk    (lnk.src)
  );

  // the serial host cannot be stalled, so a full fifo drops bytes and flags it
  sfc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (push),
    .inReady  (fifoReady),
    .inData   (pushData),
    .outValid (wrValid),
    .outReady (wrReady),
    .outData  (wrData)
  );

  function automatic sfc_kind_t op_kind(input logic [7:0] o);
    case (o)
      `SFC_OP_RD_LEGACY, `SFC_OP_RD_FAST,
      `SFC_OP_RD_SLOW, `SFC_OP_RD_LOWPWR: return KIND_RD_ARRAY;
      `SFC_OP_RD_BUF:      return KIND_RD_BUF;
      `SFC_OP_BUF_WRITE:   return KIND_BUF_WRITE;
      `SFC_OP_PROG_BUF:    return KIND_PROG_BUF;
      `SFC_OP_PROG_DIRECT: return KIND_PROG_DIRECT;
      `SFC_OP_ER_PAGE:     return KIND_ER_PAGE;
      `SFC_OP_ER_BLOCK:    return KIND_ER_BLOCK;
      `SFC_OP_ER_SECTOR:   return KIND_ER_SECTOR;
      `SFC_OP_ER_CHIP:     return KIND_ER_CHIP;
      `SFC_OP_PROT_EN:     return KIND_PROT_EN;
      `SFC_OP_LOCKDOWN:    return KIND_LOCKDOWN;
      `SFC_OP_SPR_ERASE:   return KIND_SPR_ERASE;
      `SFC_OP_SPR_PROG:    return KIND_SPR_PROG;
      default:             return KIND_NONE;
    endcase
  endfunction : op_kind

  function automatic logic is_prog_erase(input sfc_kind_t k);
    return k inside {KIND_PROG_BUF, KIND_PROG_DIRECT, KIND_ER_PAGE,
                     KIND_ER_BLOCK, KIND_ER_SECTOR, KIND_ER_CHIP};
  endfunction : is_prog_erase

  function automatic logic [2:0] dummy_bytes(input logic [7:0] o);
    case (o)
      `SFC_OP_RD_LEGACY: return `SFC_DUMMY_LEGACY;
      `SFC_OP_RD_FAST:   return `SFC_DUMMY_FAST;
      `SFC_OP_RD_BUF:    return `SFC_DUMMY_BUF;
      default:           return `SFC_DUMMY_NONE;
    endcase
  endfunction : dummy_bytes

  // returns {page, byte offset}; leading address bits are don't-care
  function automatic logic [18:0] split_addr(input logic [23:0] a, input logic bin, input logic isBuf);
    logic [9:0] pg;
    logic [8:0] by;
    if (bin)
    begin
      pg = a[`SFC_BIN_PAGE_LSB +: `SFC_PAGE_W];
      by = {1'b0, a[`SFC_BIN_PAGE_LSB-1:0]};
    end
    else
    begin
      pg = a[`SFC_STD_PAGE_LSB +: `SFC_PAGE_W];
      by = a[`SFC_BYTE_W-1:0];
    end
    if (isBuf)
      pg = '0;
    return {pg, by};
  endfunction : split_addr

  assign opKind   = op_kind(lnk.rxByte);
  assign fullAddr = {addr[15:0], lnk.rxByte};
  assign split    = split_addr(fullAddr, pageBin, kind inside {KIND_RD_BUF, KIND_BUF_WRITE});
  assign sector   = split[18:18-`SFC_PAGE_W+`SFC_SECT_LSB+1];
  // open write protect pad is pulled high, i.e. unprotected
  assign protHit  = is_prog_erase(kind) && sectorProt[sector] && (swProtOn || !wpN);

  always_comb
  begin
    next_state     = state;
    next_kind      = kind;
    next_op        = op;
    next_addr      = addr;
    next_cnt       = cnt;
    next_txSh      = txSh;
    next_txCnt     = txCnt;
    next_so        = so;
    next_soOe      = 1'b0;
    next_cmdStart  = 1'b0;
    next_cmdEnd    = 1'b0;
    next_cmdKind   = cmdKind;
    next_cmdPage   = cmdPage;
    next_cmdByte   = cmdByte;
    next_rdNext    = 1'b0;
    next_push      = 1'b0;
    next_pushData  = pushData;
    next_wrOverrun = wrOverrun;
    next_standby   = csN && !busy;
    if (!resetN)
    begin
      next_state  = ST_IDLE;
      next_cmdEnd = (state != ST_IDLE);
    end
    else if (csN)
    begin
      next_state  = ST_IDLE;
      next_cmdEnd = (state != ST_IDLE);
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // low select without a falling edge, e.g. after a reset pin pulse, is not a frame
          next_state = lnk.csFall ? ST_OPC : ST_IGNORE;
          next_cnt   = '0;
          if (lnk.csFall)
            next_wrOverrun = 1'b0;
        end
        ST_OPC:
          if (lnk.byteDone)
          begin
            next_op   = lnk.rxByte;
            next_kind = opKind;
            next_cnt  = '0;
            if (opKind == KIND_NONE)
              next_state = ST_IGNORE;
            else if (!wpN && is_prog_erase(opKind))
              next_state = ST_IGNORE;
            else if (!wpN && (opKind inside {KIND_SPR_ERASE, KIND_SPR_PROG}))
              next_state = ST_IGNORE;
            else if (opKind inside {KIND_ER_CHIP, KIND_PROT_EN, KIND_SPR_ERASE, KIND_SPR_PROG})
            begin
              next_cmdStart = 1'b1;
              next_cmdKind  = opKind;
              next_state    = (opKind == KIND_SPR_PROG) ? ST_WDATA : ST_IGNORE;
            end
            else
              next_state = ST_ADDR;
          end
        ST_ADDR:
          if (lnk.byteDone)
          begin
            next_addr = fullAddr;
            next_cnt  = cnt + 3'h1;
            if (cnt == `SFC_ADDR_LAST)
            begin
              if (protHit)
                next_state = ST_IGNORE;
              else
              begin
                next_cmdStart = 1'b1;
                next_cmdKind  = kind;
                next_cmdPage  = split[18:9];
                next_cmdByte  = split[8:0];
                next_txCnt    = '0;
                next_cnt      = dummy_bytes(op);
                if (kind inside {KIND_RD_ARRAY, KIND_RD_BUF})
                  next_state = (dummy_bytes(op) == `SFC_DUMMY_NONE) ? ST_RDATA : ST_DUMMY;
                else if (kind inside {KIND_BUF_WRITE, KIND_PROG_DIRECT})
                  next_state = ST_WDATA;
                else
                  next_state = ST_IGNORE;
              end
            end
          end
        ST_DUMMY:
          if (lnk.byteDone)
          begin
            next_cnt = cnt - 3'h1;
            if (cnt == `SFC_DUMMY_FINAL)
              next_state = ST_RDATA;
          end
        ST_RDATA:
        begin
          next_soOe = 1'b1;
          if (lnk.fall)
          begin
            if (txCnt == '0)
            begin
              next_so     = rdByte[7];
              next_txSh   = {rdByte[6:0], 1'b0};
              next_txCnt  = `SFC_BIT_LAST;
              next_rdNext = 1'b1;
            end
            else
            begin
              next_so    = txSh[7];
              next_txSh  = {txSh[6:0], 1'b0};
              next_txCnt = txCnt - 3'h1;
            end
          end
        end
        ST_WDATA:
          if (lnk.byteDone)
          begin
            if (fifoReady)
            begin
              next_push     = 1'b1;
              next_pushData = lnk.rxByte;
            end
            else
              next_wrOverrun = 1'b1;
          end
        ST_IGNORE:
          next_state = ST_IGNORE;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // rst is the internal power-on reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      kind      <= KIND_NONE;
      op        <= '0;
      addr      <= '0;
      cnt       <= '0;
      txSh      <= '0;
      txCnt     <= '0;
      so        <= 1'b0;
      soOe      <= 1'b0;
      cmdStart  <= 1'b0;
      cmdEnd    <= 1'b0;
      cmdKind   <= KIND_NONE;
      cmdPage   <= '0;
      cmdByte   <= '0;
      rdNext    <= 1'b0;
      push      <= 1'b0;
      pushData  <= '0;
      wrOverrun <= 1'b0;
      standby   <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      kind      <= next_kind;
      op        <= next_op;
      addr      <= next_addr;
      cnt       <= next_cnt;
      txSh      <= next_txSh;
      txCnt     <= next_txCnt;
      so        <= next_so;
      soOe      <= next_soOe;
      cmdStart  <= next_cmdStart;
      cmdEnd    <= next_cmdEnd;
      cmdKind   <= next_cmdKind;
      cmdPage   <= next_cmdPage;
      cmdByte   <= next_cmdByte;
      rdNext    <= next_rdNext;
      push      <= next_push;
      pushData  <= next_pushData;
      wrOverrun <= next_wrOverrun;
      standby   <= next_standby;
    end
  end

  a_wp_drops_cmd: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OPC && lnk.byteDone && !csN && resetN && !wpN && is_prog_erase(opKind))
      |=> state == ST_IGNORE ##1 !cmdStart)
    else $error("program or erase accepted under write protect");
  a_spr_locked: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OPC && lnk.byteDone && !csN && resetN && !wpN && opKind == KIND_SPR_PROG) |=> ##1 !cmdStart)
    else $error("protection register change under write protect");
  a_prot_allowed: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OPC && lnk.byteDone && !csN && resetN && !wpN && opKind == KIND_PROT_EN)
      |=> cmdStart && cmdKind == KIND_PROT_EN)
    else $error("protection enable refused under write protect");
  a_sector_guard: assert property (@(posedge clk) disable iff (rst)
    (state == ST_ADDR && lnk.byteDone && cnt == `SFC_ADDR_LAST && !csN && resetN && protHit)
      |=> !cmdStart && state == ST_IGNORE)
    else $error("protected sector program or erase issued");
  a_unknown_opc: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OPC && lnk.byteDone && !csN && resetN && opKind == KIND_NONE)
      |=> (state == ST_IGNORE && !cmdStart) [*2])
    else $error("unknown opcode not ignored");
  a_pin_reset: assert property (@(posedge clk) disable iff (rst)
    (!resetN && state != ST_IDLE) |=> state == ST_IDLE && cmdEnd)
    else $error("reset pin did not abort");
  a_deselect_hiz: assert property (@(posedge clk) disable iff (rst)
    csN |=> !soOe ##1 (!soOe || !csN))
    else $error("output driven while deselected");
  a_standby_wait: assert property (@(posedge clk) disable iff (rst)
    (csN && busy) |=> !standby)
    else $error("standby entered during busy");
  a_out_on_fall: assert property (@(posedge clk) disable iff (rst)
    (so != $past(so) && soOe && $past(soOe)) |-> $past(lnk.fall))
    else $error("output changed away from a falling edge");
endmodule : sfc_frontend
`default_nettype wire

// ===== sfc_host.sv
/*
  Host model: drives the serial link in clock mode 0, or mode 3 from the first deselect after cpol is set.
  Assumes one caller process at a time, tasks entered at a clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
  // system
  input  wire logic clk,
  // link
  output logic      csN,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  // idle level of sck between frames: 0 for mode 0, 1 for mode 3
  logic cpol;
  initial
  begin
    cpol = 1'b0;
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end
  // deselected data line keeps moving so a stale bit never looks valid
  always @(posedge clk)
    if (csN)
      si <= ~si;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic sel;
    csN <= 1'b0;
    wt(3);
  endtask : sel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck <= 1'b0;
      si  <= tx[i];
      wt(3);
      rx[i] = so;
      sck   <= 1'b1;
      wt(3);
    end
  endtask : xfer
  task automatic desel;
    sck <= cpol;
    wt(3);
    csN <= 1'b1;
    wt(6);
  endtask : desel
endmodule : sfc_host
`default_nettype wire

// ===== test_serial_flash_command_frontend.sv
/*
  Self-checking testbench of the command front end.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_command_frontend;
  import sfc_pkg::*;
  logic       clk, rst, wpN, resetN, pageBin, swProtOn, busy, wrReady;
  logic       csN, sck, si, so, soOe, cmdStart, cmdEnd, rdNext, wrValid, wrOverrun, standby, oe;
  logic [7:0] sectorProt, rdByte, wrData, r0, r1, rx;
  logic [9:0] cmdPage;
  logic [8:0] cmdByte;
  sfc_kind_t  cmdKind;
  int         errCount = 0, checks = 0, nStart = 0, nEnd = 0, s0, e0;
  sfc_frontend i_dut (.clk, .rst, .csN, .sck, .si, .so, .soOe, .wpN, .resetN, .pageBin, .swProtOn,
    .sectorProt, .cmdStart, .cmdEnd, .cmdKind, .cmdPage, .cmdByte, .rdByte, .rdNext, .wrData,
    .wrValid, .wrReady, .wrOverrun, .busy, .standby);
  // released output reads as the inverse, so data taken without enable fails
  sfc_host i_host (.clk, .csN, .sck, .si, .so (soOe ? so : !so));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // back end: read bytes count up from a known base
  always @(posedge clk)
  begin
    if (cmdStart)
      rdByte <= 8'hA5;
    else if (rdNext)
      rdByte <= rdByte + 8'h01;
    nStart <= nStart + int'(cmdStart);
    nEnd   <= nEnd + int'(cmdEnd);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d, errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic frame(input logic [7:0] op, input int na, input logic [23:0] a, input int nb,
                       input logic [7:0] d);
    s0 = nStart;
    e0 = nEnd;
    i_host.sel();
    i_host.xfer(op, rx);
    for (int k = 0; k < na; k++)
      i_host.xfer(a[23-8*k -: 8], rx);
    for (int k = 0; k < nb; k++)
    begin
      r0 = r1;
      i_host.xfer(d + 8'(k), rx);
      r1 = rx;
    end
    oe = soOe;
    i_host.desel();
  endtask : frame
  task automatic read_case(input logic pb, input logic [7:0] op, input int nd, input sfc_kind_t k,
                           input logic [23:0] a, input logic [9:0] pg, input logic [8:0] by);
    pageBin <= pb;
    frame(op, 3, a, nd + 2, 8'h00);
    chk(nStart - s0, 1);
    chk(cmdKind, k);
    chk(cmdPage, pg);
    chk(cmdByte, by);
    chk({r0, r1}, 16'hA5A6);
    chk(oe, 1'b1);
    chk(soOe, 1'b0);
    chk(nEnd - e0, 1);
  endtask : read_case
  task automatic cmd_case(input logic w, input logic sw, input logic [7:0] op, input int na,
                          input logic [23:0] a, input int expStart);
    wpN      <= w;
    swProtOn <= sw;
    frame(op, na, a, 1, 8'h00);
    chk(nStart - s0, expStart);
    chk(nEnd - e0, 1);
  endtask : cmd_case
  initial
  begin
    rst = 1'b1;
    wpN = 1'b1;
    resetN = 1'b1;
    pageBin = 1'b0;
    swProtOn = 1'b0;
    busy = 1'b0;
    wrReady = 1'b0;
    sectorProt = 8'h08;
    repeat (4) @(posedge clk);
    chk(standby, 1'b1);
    chk(cmdKind, KIND_NONE);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    read_case(1'b0, 8'h03, 0, KIND_RD_ARRAY, 24'h85_5755, 10'h2AB, 9'h155);
    read_case(1'b1, 8'h0B, 1, KIND_RD_ARRAY, 24'h03_C17E, 10'h3C1, 9'h07E);
    read_case(1'b1, 8'h01, 0, KIND_RD_ARRAY, 24'h02_0000, 10'h200, 9'h000);
    read_case(1'b1, 8'h10, 1, KIND_RD_BUF, 24'hFF_FF07, 10'h000, 9'h007);
    // sck idles high once the next read deselects, so the read after it runs in clock mode 3
    i_host.cpol <= 1'b1;
    read_case(1'b0, 8'h10, 1, KIND_RD_BUF, 24'hFF_FF07, 10'h000, 9'h107);
    read_case(1'b0, 8'hE8, 4, KIND_RD_ARRAY, 24'h00_03FF, 10'h001, 9'h1FF);
    // reset pin pulled low mid-address, bits during reset discarded
    s0 = nStart;
    e0 = nEnd;
    i_host.sel();
    i_host.xfer(8'h03, rx);
    resetN <= 1'b0;
    i_host.xfer(8'h00, rx);
    chk(nEnd - e0, 1);
    resetN <= 1'b1;
    i_host.xfer(8'h00, rx);
    i_host.xfer(8'h00, rx);
    i_host.desel();
    // select still low at release: frame ignored, its close counts a second end
    chk(nStart - s0, 0);
    chk(nEnd - e0, 2);
    for (int k = 0; k < 5; k++)
      cmd_case(1'b0, 1'b0, 8'h12 + 8'(k), 3, 24'h00_0000, 0);
    cmd_case(1'b0, 1'b0, 8'h17, 0, 24'h00_0000, 0);
    cmd_case(1'b0, 1'b0, 8'h18, 0, 24'h00_0000, 1);
    cmd_case(1'b0, 1'b0, 8'h19, 3, 24'h03_0000, 1);
    cmd_case(1'b0, 1'b0, 8'h1A, 0, 24'h00_0000, 0);
    cmd_case(1'b0, 1'b0, 8'h1B, 0, 24'h00_0000, 0);
    cmd_case(1'b1, 1'b1, 8'h14, 3, 24'h03_0000, 0);
    cmd_case(1'b1, 1'b1, 8'h14, 3, 24'h02_0000, 1);
    cmd_case(1'b1, 1'b0, 8'h14, 3, 24'h03_0000, 1);
    cmd_case(1'b1, 1'b0, 8'hFF, 0, 24'h00_0000, 0);
    // fill past 16 with the back end stalled, then drain
    frame(8'h11, 3, 24'h00_0000, 17, 8'h40);
    chk(wrOverrun, 1'b1);
    wrReady <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      @(negedge clk);
      chk(wrValid, 1'b1);
      chk(wrData, 8'h40 + 8'(k));
    end
    @(negedge clk);
    chk(wrValid, 1'b0);
    @(posedge clk);
    wrReady <= 1'b0;
    i_host.sel();
    chk(wrOverrun, 1'b0);
    i_host.desel();
    busy <= 1'b1;
    frame(8'h18, 0, 24'h00_0000, 0, 8'h00);
    chk(standby, 1'b0);
    busy <= 1'b0;
    i_host.wt(3);
    chk(standby, 1'b1);
    end_of_test();
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    errCount++;
    end_of_test();
  end
endmodule : test_serial_flash_command_frontend
`default_nettype wire
